// ### rtl/txport_pkg.sv
// Shared constants for the transmitter serial port and power control block.
package txport_pkg;
    // Clock rates in MHz; the device input clock is the reference for the documented figures.
    localparam int CLK_MHZ = 250;
    localparam int IN_MHZ = 32;
    // Low-power timeout: 2^18 input clocks, about 8.2 ms.
    localparam int LP_INPUT_CLOCKS = 262144;
    localparam int LP_CYCLES = LP_INPUT_CLOCKS * CLK_MHZ / IN_MHZ;
    localparam int LP_W = 22;
    // Divided clock: input clock over 16, 2 MHz; half period rounded down to whole cycles.
    localparam int CK_DIV = 16;
    localparam int CK_HALF = CLK_MHZ * CK_DIV / (2 * IN_MHZ);
    localparam int CK_W = 6;
    // Command field codes.
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_NONE = 2'h2;
    localparam logic [1:0] CMD_TX = 2'h3;
    // Interface select location and codes.
    localparam logic [5:0] INTERFACE_SELECT_FIELD_ADDR = 6'h15;
    localparam logic [1:0] IF_3WIRE = 2'h0;
    localparam logic [1:0] IF_4WIRE = 2'h1;
    localparam logic [1:0] IF_3WIRE_AUX = 2'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Power-amplifier-mode bit within the captured transmit configuration.
    localparam int TXB_BIT = 4;
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b01,
        ST_ACTIVE = 2'b10
    } pwr_t;
    typedef enum logic [4:0] {
        PH_HEAD = 5'b00001,
        PH_WRITE = 5'b00010,
        PH_READ = 5'b00100,
        PH_TX = 5'b01000,
        PH_IDLE = 5'b10000
    } phase_t;
endpackage

// ### rtl/txport_top.sv
// Serial host port, control register space and enable-pin power control of the transmitter.
//
// How it works
// - Enable rising wakes the chip into clock-buffer-active and starts the 2 MHz output.
// - Every enable falling edge clears bit counter, command and address capture.
// - Enable held low for 2^18 input clocks returns the chip to low power.
// - After a transmit command with mode bit set, enable falling latches the data pin, or the aux pin in three-wire aux mode.
// - Incoming serial data is sampled on the serial clock falling edge.
// - Port runs three-wire or four-wire, for register access and transmit commands.
// - A detected failure removes the power amplifier supply.
// - A divided input clock is driven on the divided clock output.
// - Serial output data changes on the serial clock rising edge.
// - Interface select: 00 three-wire, 01 four-wire, 10 three-wire with aux data.
`timescale 1ns/100ps
module txport_top #(
    parameter int LP_CYCLES = txport_pkg::LP_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic EN_I,
    input wire logic SCK_I,
    input wire logic SDIO_I,
    input wire logic AUX_DATA_PIN_I,
    input wire logic FAIL_DETECT_I,
    output logic SDIO_O,
    output logic SDIO_OE_O,
    output logic AUX_DATA_PIN_O,
    output logic AUX_DATA_PIN_OE_O,
    output logic DIVIDED_CLOCK_OUTPUT_O,
    output logic CLOCK_BUFFER_ACTIVE_O,
    output logic POWER_AMPLIFIER_SUPPLY_O,
    output logic TX_DATA_O,
    output logic [5:0] TX_CONFIG_O
);
    // Width of the timeout counter, declared ahead of the logic and checks that size casts with it.
    localparam int LP_W = txport_pkg::LP_W;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection of the host pins, which are synchronous to our clock.
    logic en_q, sck_q;
    logic en_rise, en_fall, sck_rise, sck_fall, din;
    logic [7:0] regs [64];
    logic [1:0] interface_select_field;

    assign interface_select_field = regs[txport_pkg::INTERFACE_SELECT_FIELD_ADDR][1:0];
    assign en_rise = EN_I & ~en_q;
    assign en_fall = ~EN_I & en_q;
    assign sck_rise = EN_I & SCK_I & ~sck_q;
    assign sck_fall = EN_I & ~SCK_I & sck_q;
    assign din = SDIO_I;

    // Previous pin levels.
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            en_q <= 1'b0;
            sck_q <= 1'b0;
        end
        else
        begin
            en_q <= EN_I;
            sck_q <= SCK_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state, timeout counter and clock divider.
    txport_pkg::pwr_t st_q, st_d;
    logic [txport_pkg::LP_W-1:0] lp_q, lp_d;
    logic [txport_pkg::CK_W-1:0] ck_cnt_q, ck_cnt_d;
    logic ck_q, ck_d;

    // The divider restarts on wake so the first divided pulse has full width.
    always_comb
    begin
        st_d = st_q;
        lp_d = lp_q;
        ck_cnt_d = ck_cnt_q;
        ck_d = ck_q;
        if (EN_I)
            lp_d = '0;
        else if (st_q == txport_pkg::ST_ACTIVE)
            lp_d = lp_q + 1'b1;
        if (st_q == txport_pkg::ST_SLEEP)
        begin
            ck_cnt_d = '0;
            ck_d = 1'b0;
            if (en_rise)
                st_d = txport_pkg::ST_ACTIVE;
        end
        else
        begin
            if (!EN_I && lp_q == LP_W'(LP_CYCLES - 1))
            begin
                st_d = txport_pkg::ST_SLEEP;
                lp_d = '0;
            end
            if (ck_cnt_q == txport_pkg::CK_W'(txport_pkg::CK_HALF - 1))
            begin
                ck_cnt_d = '0;
                ck_d = ~ck_q;
            end
            else
                ck_cnt_d = ck_cnt_q + 1'b1;
        end
    end

    // Power state registers.
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st_q <= txport_pkg::ST_SLEEP;
            lp_q <= '0;
            ck_cnt_q <= '0;
            ck_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            lp_q <= lp_d;
            ck_cnt_q <= ck_cnt_d;
            ck_q <= ck_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial command engine.
    txport_pkg::phase_t ph_q, ph_d;
    logic [2:0] bit_q, bit_d;
    logic [6:0] sh_q, sh_d;
    logic [5:0] addr_q, addr_d;
    logic [7:0] obyte_q, obyte_d, byte_in;
    logic [5:0] cfg_q, cfg_d;
    logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d, aux_oe_q, aux_oe_d;
    logic txd_q, txd_d, pa_q, pa_d, fail_q, fail_d, we;
    logic [5:0] waddr;

    assign byte_in = {sh_q, din};

    // Bits are sampled on serial clock falls; read data moves on rises only.
    always_comb
    begin
        ph_d = ph_q;
        bit_d = bit_q;
        sh_d = sh_q;
        addr_d = addr_q;
        obyte_d = obyte_q;
        cfg_d = cfg_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        aux_oe_d = aux_oe_q;
        txd_d = txd_q;
        pa_d = pa_q;
        fail_d = fail_q | FAIL_DETECT_I;
        we = 1'b0;
        waddr = addr_q;
        if (en_fall)
        begin
            ph_d = txport_pkg::PH_HEAD;
            bit_d = '0;
            sh_d = '0;
            addr_d = '0;
            sdo_oe_d = 1'b0;
            aux_oe_d = 1'b0;
            if (ph_q == txport_pkg::PH_TX)
            begin
                if (cfg_q[txport_pkg::TXB_BIT])
                    txd_d = (interface_select_field == txport_pkg::IF_3WIRE_AUX) ? AUX_DATA_PIN_I : SDIO_I;
                else
                    pa_d = 1'b0;
            end
        end
        else if (sck_fall)
        begin
            sh_d = byte_in[6:0];
            bit_d = bit_q + 1'b1;
            if (bit_q == 3'h7)
            begin
                addr_d = addr_q + 1'b1;
                case (ph_q)
                    txport_pkg::PH_HEAD:
                    begin
                        addr_d = byte_in[5:0];
                        obyte_d = regs[byte_in[5:0]];
                        case (byte_in[7:6])
                            txport_pkg::CMD_READ:
                            begin
                                // Read data is preloaded here, so the pointer already moves to the next byte.
                                ph_d = txport_pkg::PH_READ;
                                addr_d = byte_in[5:0] + 1'b1;
                            end
                            txport_pkg::CMD_WRITE: ph_d = txport_pkg::PH_WRITE;
                            txport_pkg::CMD_TX:
                            begin
                                ph_d = txport_pkg::PH_TX;
                                cfg_d = byte_in[5:0];
                            end
                            default: ph_d = txport_pkg::PH_IDLE;
                        endcase
                    end
                    txport_pkg::PH_WRITE: we = 1'b1;
                    txport_pkg::PH_READ: obyte_d = regs[addr_q];
                    default: addr_d = addr_q;
                endcase
            end
        end
        else if (sck_rise)
        begin
            if (ph_q == txport_pkg::PH_READ)
            begin
                sdo_d = obyte_q[3'h7 - bit_q];
                sdo_oe_d = (interface_select_field != txport_pkg::IF_4WIRE);
                aux_oe_d = (interface_select_field == txport_pkg::IF_4WIRE);
            end
            if (ph_q == txport_pkg::PH_TX)
                pa_d = 1'b1;
        end
        if (st_q == txport_pkg::ST_SLEEP)
        begin
            fail_d = FAIL_DETECT_I;
            pa_d = 1'b0;
        end
        if (fail_d)
            pa_d = 1'b0;
    end

    // Serial engine registers.
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ph_q <= txport_pkg::PH_HEAD;
            bit_q <= '0;
            sh_q <= '0;
            addr_q <= '0;
            obyte_q <= '0;
            cfg_q <= '0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            aux_oe_q <= 1'b0;
            txd_q <= 1'b0;
            pa_q <= 1'b0;
            fail_q <= 1'b0;
        end
        else
        begin
            ph_q <= ph_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            obyte_q <= obyte_d;
            cfg_q <= cfg_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            aux_oe_q <= aux_oe_d;
            txd_q <= txd_d;
            pa_q <= pa_d;
            fail_q <= fail_d;
        end
    end

    // Control register space; burst writes land one byte per data byte.
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            for (int i = 0; i < 64; i++)
                regs[i] <= txport_pkg::REG_RESET;
        end
        else if (we)
            regs[waddr] <= byte_in;
    end

    assign SDIO_O = sdo_q;
    assign SDIO_OE_O = sdo_oe_q;
    assign AUX_DATA_PIN_O = sdo_q;
    assign AUX_DATA_PIN_OE_O = aux_oe_q;
    assign DIVIDED_CLOCK_OUTPUT_O = ck_q;
    assign CLOCK_BUFFER_ACTIVE_O = st_q[1];
    assign POWER_AMPLIFIER_SUPPLY_O = pa_q;
    assign TX_DATA_O = txd_q;
    assign TX_CONFIG_O = cfg_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_wake_on_en: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        en_rise |=> st_q == txport_pkg::ST_ACTIVE) else $error("no wake on enable rise");
    a_fall_reinit: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        en_fall |=> bit_q == 3'h0 && ph_q == txport_pkg::PH_HEAD) else $error("port not reinitialised");
    a_sleep_timeout: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        st_q == txport_pkg::ST_ACTIVE && !EN_I && lp_q == LP_W'(LP_CYCLES - 1)
        |=> st_q == txport_pkg::ST_SLEEP) else $error("timeout missed");
    a_lp_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        EN_I |=> lp_q == '0) else $error("timeout counter not cleared");
    a_tx_latch: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        en_fall && ph_q == txport_pkg::PH_TX && cfg_q[txport_pkg::TXB_BIT] && interface_select_field != txport_pkg::IF_3WIRE_AUX
        |=> TX_DATA_O == $past(SDIO_I)) else $error("transmit data not latched");
    a_sample_fall: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        sck_fall && !en_fall |=> sh_q[0] == $past(SDIO_I)) else $error("bit not sampled");
    a_out_on_rise: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        !sck_rise |=> $stable(sdo_q)) else $error("output moved off rising edge");
    a_fail_cut: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        FAIL_DETECT_I |=> !POWER_AMPLIFIER_SUPPLY_O ##1 !POWER_AMPLIFIER_SUPPLY_O) else $error("supply not cut");
    a_divided_clock_output_half: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        $rose(ck_q) |-> ##62 (!ck_q || st_q == txport_pkg::ST_SLEEP)) else $error("divided clock period wrong");
    a_four_wire: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        AUX_DATA_PIN_OE_O |-> !SDIO_OE_O && interface_select_field == txport_pkg::IF_4WIRE) else $error("wrong output pin");
endmodule

// ### dv/host_model.sv
// Host microcontroller model that drives the enable, serial clock and data pins.
`timescale 1ns/100ps
module host_model (
    input wire logic clk_i,
    input wire logic sdio_w_i,
    input wire logic aux_w_i,
    output logic en_o,
    output logic sck_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic aux_o,
    output logic aux_oe_o
);
    logic four = 1'b0;
    // Pins start idle; the host owns no line until a frame begins.
    initial
    begin
        {en_o, sck_o, sdo_o, sdo_oe_o, aux_o, aux_oe_o} = 6'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Frame edges; levels are held for whole clocks, far slower than real silicon needs.
    task automatic start();
        @(negedge clk_i) en_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask
    // Data is held one clock past the enable fall, because a transmit bit is latched on that edge.
    task automatic stop();
        en_o = 1'b0;
        @(negedge clk_i);
        sdo_oe_o = 1'b0;
        @(negedge clk_i);
    endtask
    // One serial clock high pulse; three clocks high so the answer has settled.
    task automatic pulse();
        sck_o = 1'b1;
        repeat (3) @(negedge clk_i);
        sck_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    // Shifts nb bits MSB first; read data is taken just before the clock falls.
    task automatic xfer(input logic [7:0] d, input int nb, input bit drv, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--)
        begin
            sdo_oe_o = drv;
            sdo_o = d[i];
            sck_o = 1'b1;
            repeat (3) @(negedge clk_i);
            r[i] = four ? aux_w_i : sdio_w_i;
            sck_o = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the serial port and power control block.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic fail = 1'b0;
    logic en, sck, sdo, sdo_oe, aux, aux_oe, sdio_w, aux_w;
    logic sdio_o, sdio_oe_o, aux_o, aux_oe_o, div_o, act_o, pa_o, txd_o;
    logic [5:0] cfg_o;
    logic [7:0] mdl [64];
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'hdf31;
    localparam int LP = 64;
    // Free-running 250 MHz clock.
    always #2 clk = ~clk;
    // Released lines fall to the pin pull-down level.
    assign sdio_w = sdio_oe_o ? sdio_o : (sdo_oe ? sdo : 1'b0);
    assign aux_w = aux_oe_o ? aux_o : (aux_oe ? aux : 1'b0);
    host_model host (.clk_i(clk), .sdio_w_i(sdio_w), .aux_w_i(aux_w), .en_o(en), .sck_o(sck), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe), .aux_o(aux), .aux_oe_o(aux_oe));
    txport_top #(.LP_CYCLES(LP)) dut (.CLOCK_I(clk), .RST_B_I(rst_b), .EN_I(en), .SCK_I(sck), .SDIO_I(sdio_w),
        .AUX_DATA_PIN_I(aux_w), .FAIL_DETECT_I(fail), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe_o),
        .AUX_DATA_PIN_O(aux_o), .AUX_DATA_PIN_OE_O(aux_oe_o), .DIVIDED_CLOCK_OUTPUT_O(div_o),
        .CLOCK_BUFFER_ACTIVE_O(act_o), .POWER_AMPLIFIER_SUPPLY_O(pa_o), .TX_DATA_O(txd_o), .TX_CONFIG_O(cfg_o));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One register frame; the model array tracks writes and predicts reads.
    task automatic acc(input logic [1:0] cmd, input logic [5:0] a, input int n, input bit rnd, input logic [7:0] d0);
        logic [7:0] r, d;
        host.start();
        host.xfer({cmd, a}, 8, 1'b1, r);
        for (int i = 0; i < n; i++)
        begin
            d = rnd ? 8'($random(seed)) : d0;
            host.xfer(d, 8, cmd != txport_pkg::CMD_READ, r);
            if (cmd == txport_pkg::CMD_WRITE)
                mdl[a] = d;
            if (cmd == txport_pkg::CMD_READ)
                `CHK(r, mdl[a])
            a = a + 6'h01;
        end
        host.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized well beyond the expected run of some 1,800 clocks.
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
    // Main sequence.
    initial
    begin
        logic [7:0] r;
        logic [5:0] cfg;
        logic bitv;
        int n;
        foreach (mdl[i]) mdl[i] = txport_pkg::REG_RESET;
        repeat (12) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        `CHK(act_o, 1'b0)
        host.start();
        `CHK(act_o, 1'b1)
        n = 0;
        while (div_o !== 1'b1 && n < 300) @(negedge clk) n++;
        n = 0;
        while (div_o === 1'b1 && n < 300) @(negedge clk) n++;
        `CHK(n, txport_pkg::CK_HALF)
        host.stop();
        // Burst write across the address wrap, then read back, plus untouched places.
        acc(txport_pkg::CMD_WRITE, 6'h3E, 4, 1'b1, 8'h00);
        acc(txport_pkg::CMD_READ, 6'h3E, 4, 1'b0, 8'h00);
        acc(txport_pkg::CMD_READ, 6'h20, 2, 1'b0, 8'h00);
        // A frame cut off mid-byte leaves nothing behind.
        host.start();
        host.xfer({txport_pkg::CMD_WRITE, 6'h20}, 8, 1'b1, r);
        host.xfer(8'hA5, 4, 1'b1, r);
        host.stop();
        acc(txport_pkg::CMD_NONE, 6'h20, 2, 1'b1, 8'h00);
        acc(txport_pkg::CMD_READ, 6'h20, 2, 1'b0, 8'h00);
        // Four-wire read returns data on the auxiliary pin.
        acc(txport_pkg::CMD_WRITE, txport_pkg::INTERFACE_SELECT_FIELD_ADDR, 1, 1'b0, {6'h00, txport_pkg::IF_4WIRE});
        host.four = 1'b1;
        acc(txport_pkg::CMD_READ, 6'h3E, 3, 1'b0, 8'h00);
        acc(txport_pkg::CMD_WRITE, txport_pkg::INTERFACE_SELECT_FIELD_ADDR, 1, 1'b0, {6'h00, txport_pkg::IF_3WIRE});
        host.four = 1'b0;
        // Transmit: mode bit clear, set on data pin, set on auxiliary pin, set with a detected failure.
        for (int k = 0; k < 4; k++)
        begin
            if (k == 2)
                acc(txport_pkg::CMD_WRITE, txport_pkg::INTERFACE_SELECT_FIELD_ADDR, 1, 1'b0, {6'h00, txport_pkg::IF_3WIRE_AUX});
            cfg = 6'($random(seed));
            cfg[txport_pkg::TXB_BIT] = (k != 0);
            bitv = 1'($random(seed));
            host.start();
            host.xfer({txport_pkg::CMD_TX, cfg}, 8, 1'b1, r);
            `CHK(cfg_o, cfg)
            host.pulse();
            `CHK(pa_o, 1'b1)
            if (k == 3)
            begin
                @(negedge clk) fail = 1'b1;
                @(negedge clk) fail = 1'b0;
                `CHK(pa_o, 1'b0)
            end
            host.sdo_o = (k == 2) ? ~bitv : bitv;
            host.aux_o = bitv;
            host.aux_oe_o = (k == 2);
            host.stop();
            if (k == 1 || k == 2)
                `CHK(txd_o, bitv)
            `CHK(pa_o, k == 1 || k == 2)
            host.aux_oe_o = 1'b0;
            if (k == 2)
                acc(txport_pkg::CMD_WRITE, txport_pkg::INTERFACE_SELECT_FIELD_ADDR, 1, 1'b0, {6'h00, txport_pkg::IF_3WIRE});
        end
        // Low-power timeout restarts on enable and then expires.
        repeat (LP - 8) @(negedge clk);
        host.start();
        host.stop();
        repeat (LP - 8) @(negedge clk);
        `CHK(act_o, 1'b1)
        repeat (16) @(negedge clk);
        `CHK(act_o, 1'b0)
        `CHK(div_o, 1'b0)
        report_and_stop();
    end
endmodule
